// ==== shared/dma_regs_pkg.sv ====
// Port map, field layout and reset values of the four-channel transfer controller registers
package dma_regs_pkg;

  // ----------------------------------------------------------------
  // Port offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] PORT_CMD_STATUS = 4'h8;
  localparam logic [3:0] PORT_SW_REQUEST = 4'h9;
  localparam logic [3:0] PORT_SINGLE_MASK = 4'ha;
  localparam logic [3:0] PORT_MODE = 4'hb;
  localparam logic [3:0] PORT_CLEAR_POINTER = 4'hc;
  localparam logic [3:0] PORT_MASTER_CLEAR = 4'hd;
  localparam logic [3:0] PORT_CLEAR_MASKS = 4'he;
  localparam logic [3:0] PORT_ALL_MASKS = 4'hf;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_MEM_TO_MEM = 0;
  localparam int CMD_ADDR_HOLD = 1;
  localparam int CMD_DISABLE = 2;
  localparam int CMD_COMPRESSED = 3;
  localparam int CMD_ROTATING = 4;
  localparam int CMD_EXT_WRITE = 5;
  localparam int CMD_REQ_LOW = 6;
  localparam int CMD_GRANT_HIGH = 7;
  localparam int SEL_SET_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam logic [3:0] MASK_RESET = 4'hf;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] TEMP_RESET = 8'h00;

  typedef enum logic [1:0] {
    DEMAND_MODE  = 2'b00,
    SINGLE_MODE  = 2'b01,
    BLOCK_MODE   = 2'b10,
    CASCADE_MODE = 2'b11
  } op_mode_type;

  typedef enum logic [1:0] {
    VERIFY_XFER  = 2'b00,
    WRITE_XFER   = 2'b01,
    READ_XFER    = 2'b10,
    ILLEGAL_XFER = 2'b11
  } xfer_type;

  typedef struct packed {
    op_mode_type op;
    logic        decrement;
    logic        autoinit;
    xfer_type    xfer;
  } mode_type;

  localparam mode_type MODE_RESET = '{op: DEMAND_MODE, decrement: 1'b0,
                                      autoinit: 1'b0, xfer: VERIFY_XFER};

  typedef struct packed {
    logic       mem_to_mem;
    logic       addr_hold;
    logic       disable_all;
    logic       compressed;
    logic       rotating;
    logic       ext_write;
    logic       req_active_low;
    logic       grant_active_high;
  } effective_cmd_type;

endpackage

// ==== logic/dma_register_file.sv ====
// Register interface of the four-channel transfer controller on a byte-wide I/O bus
//
// Function
// - Address port write loads base and current
// - Address port read returns current address
// - Count port loads base, current; reads current
// - Command: mem-to-mem, address hold, controller disable
// - Command: compressed timing, rotating priority, extended write
// - Command: request and grant polarities
// - Status read: terminal count, pending requests
// - Request port sets or resets one request
// - Single mask port updates one mask bit
// - Mode port loads autoinit, direction, operation
// - Transfer type field, ignored in cascade
// - Clear port resets byte pointer
// - Master clear write; temporary register read
// - Clear-masks port enables all channels
// - All-masks port loads four mask bits
module dma_register_file (
  input  wire logic                             REF_CLK,
  input  wire logic                             RESET_N,
  input  wire logic [3:0]                       IO_ADDR,
  input  wire logic [7:0]                       IO_DATA_IN,
  input  wire logic                             io_write_strobe_n,
  input  wire logic                             io_read_strobe_n,
  input  wire logic [3:0]                       TERMINAL_COUNT,
  input  wire logic [3:0]                       channel_request_in,
  input  wire logic [7:0]                       TEMP_DATA,
  input  wire logic                             TEMP_LOAD,
  output logic      [7:0]                       IO_DATA_OUT,
  output logic                                  IO_DATA_OE,
  output dma_regs_pkg::effective_cmd_type       COMMAND,
  output logic      [3:0]                       CHANNEL_MASK,
  output logic      [3:0]                       SOFTWARE_REQUEST,
  output dma_regs_pkg::mode_type [3:0]          CHANNEL_MODE,
  output logic      [63:0]                      BASE_ADDRESS,
  output logic      [63:0]                      BASE_COUNT,
  output logic                                  BYTE_POINTER
);

  // ----------------------------------------------------------------
  // Strobe edge detection
  // ----------------------------------------------------------------
  // One access per strobe: act on the falling edge so a long strobe
  // does not toggle the byte pointer many times.
  logic        write_strobe_q;
  logic        read_strobe_q;
  logic [7:0]  command;
  logic [3:0]  mask;
  logic [3:0]  request;
  logic [3:0]  tc_flag;
  logic [7:0]  temp;
  logic        pointer;
  logic [15:0] base_addr [4];
  logic [15:0] cur_addr [4];
  logic [15:0] base_cnt [4];
  logic [15:0] cur_cnt [4];
  dma_regs_pkg::mode_type mode [4];

  wire write_pulse = write_strobe_q & ~io_write_strobe_n;
  wire read_pulse = read_strobe_q & ~io_read_strobe_n;
  wire word_port = ~IO_ADDR[3];
  wire [1:0] word_chan = IO_ADDR[2:1];
  wire count_port = IO_ADDR[0];
  wire [1:0] sel_chan = IO_DATA_IN[1:0];
  wire sel_set = IO_DATA_IN[dma_regs_pkg::SEL_SET_BIT];
  wire master_clear = write_pulse && IO_ADDR == dma_regs_pkg::PORT_MASTER_CLEAR;

  function automatic logic port_write(input logic [3:0] port);
    return write_pulse && IO_ADDR == port;
  endfunction

  function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic high);
    return high ? word[15:8] : word[7:0];
  endfunction

  // Named port writes: assertions must sample these before the edge moves the strobe copy
  wire command_write = port_write(dma_regs_pkg::PORT_CMD_STATUS);
  wire request_write = port_write(dma_regs_pkg::PORT_SW_REQUEST);
  wire single_mask_write = port_write(dma_regs_pkg::PORT_SINGLE_MASK);
  wire mode_write = port_write(dma_regs_pkg::PORT_MODE);
  wire pointer_clear_write = port_write(dma_regs_pkg::PORT_CLEAR_POINTER);
  wire clear_masks_write = port_write(dma_regs_pkg::PORT_CLEAR_MASKS);
  wire all_masks_write = port_write(dma_regs_pkg::PORT_ALL_MASKS);

  // Cascade channels keep no transfer type, so it is dropped on entry
  wire cascade_in = IO_DATA_IN[7:6] == dma_regs_pkg::CASCADE_MODE;
  wire [1:0] xfer_in = cascade_in ? dma_regs_pkg::VERIFY_XFER : IO_DATA_IN[3:2];
  dma_regs_pkg::mode_type mode_in;
  assign mode_in = dma_regs_pkg::mode_type'({IO_DATA_IN[7:4], xfer_in});

  // ----------------------------------------------------------------
  // Per-channel word registers
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_chan
      wire hit = write_pulse && word_port && word_chan == ch;
      always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          base_addr[ch] <= dma_regs_pkg::WORD_RESET;
          cur_addr[ch] <= dma_regs_pkg::WORD_RESET;
          base_cnt[ch] <= dma_regs_pkg::WORD_RESET;
          cur_cnt[ch] <= dma_regs_pkg::WORD_RESET;
          mode[ch] <= dma_regs_pkg::MODE_RESET;
        end else begin
          if (hit && !count_port && !pointer) begin
            base_addr[ch][7:0] <= IO_DATA_IN;
            cur_addr[ch][7:0] <= IO_DATA_IN;
          end
          if (hit && !count_port && pointer) begin
            base_addr[ch][15:8] <= IO_DATA_IN;
            cur_addr[ch][15:8] <= IO_DATA_IN;
          end
          if (hit && count_port && !pointer) begin
            base_cnt[ch][7:0] <= IO_DATA_IN;
            cur_cnt[ch][7:0] <= IO_DATA_IN;
          end
          if (hit && count_port && pointer) begin
            base_cnt[ch][15:8] <= IO_DATA_IN;
            cur_cnt[ch][15:8] <= IO_DATA_IN;
          end
          if (mode_write && sel_chan == ch) begin
            mode[ch] <= mode_in;
          end
        end
      end
      assign BASE_ADDRESS[16*ch +: 16] = base_addr[ch];
      assign BASE_COUNT[16*ch +: 16] = base_cnt[ch];
      assign CHANNEL_MODE[ch] = mode[ch];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  wire [3:0] sel_onehot = 4'h1 << sel_chan;
  wire word_access = word_port && (write_pulse || read_pulse);
  wire [3:0] next_mask =
      port_write(dma_regs_pkg::PORT_ALL_MASKS) ? IO_DATA_IN[3:0] :
      port_write(dma_regs_pkg::PORT_CLEAR_MASKS) ? 4'h0 :
      port_write(dma_regs_pkg::PORT_SINGLE_MASK) ?
        (sel_set ? (mask | sel_onehot) : (mask & ~sel_onehot)) : mask;
  wire [3:0] next_request = port_write(dma_regs_pkg::PORT_SW_REQUEST) ?
      (sel_set ? (request | sel_onehot) : (request & ~sel_onehot)) : request;
  wire status_read = read_pulse && IO_ADDR == dma_regs_pkg::PORT_CMD_STATUS;
  wire [3:0] req_seen = command[dma_regs_pkg::CMD_REQ_LOW] ?
      ~channel_request_in : channel_request_in;
  // Status read clears terminal flags; a new count wins over the clear
  wire [3:0] next_tc = (status_read ? 4'h0 : tc_flag) | TERMINAL_COUNT;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      write_strobe_q <= 1'b1;
      read_strobe_q <= 1'b1;
      command <= dma_regs_pkg::COMMAND_RESET;
      mask <= dma_regs_pkg::MASK_RESET;
      request <= 4'h0;
      tc_flag <= 4'h0;
      temp <= dma_regs_pkg::TEMP_RESET;
      pointer <= 1'b0;
    end else if (master_clear) begin
      write_strobe_q <= io_write_strobe_n;
      read_strobe_q <= io_read_strobe_n;
      command <= dma_regs_pkg::COMMAND_RESET;
      mask <= dma_regs_pkg::MASK_RESET;
      request <= 4'h0;
      tc_flag <= 4'h0;
      temp <= dma_regs_pkg::TEMP_RESET;
      pointer <= 1'b0;
    end else begin
      write_strobe_q <= io_write_strobe_n;
      read_strobe_q <= io_read_strobe_n;
      if (port_write(dma_regs_pkg::PORT_CMD_STATUS)) begin
        command <= IO_DATA_IN;
      end
      mask <= next_mask;
      request <= next_request;
      tc_flag <= next_tc;
      if (TEMP_LOAD) begin
        temp <= TEMP_DATA;
      end
      if (port_write(dma_regs_pkg::PORT_CLEAR_POINTER)) begin
        pointer <= 1'b0;
      end else if (word_access) begin
        pointer <= ~pointer;
      end
    end
  end

  // ----------------------------------------------------------------
  // Effective command decode and read data
  // ----------------------------------------------------------------
  wire m2m = command[dma_regs_pkg::CMD_MEM_TO_MEM];
  wire comp = command[dma_regs_pkg::CMD_COMPRESSED] & ~m2m;
  wire [7:0] status_byte = {request | req_seen, tc_flag};
  wire [7:0] word_byte = count_port ? pick_byte(cur_cnt[word_chan], pointer)
                                    : pick_byte(cur_addr[word_chan], pointer);
  wire readable = word_port || IO_ADDR == dma_regs_pkg::PORT_CMD_STATUS ||
                  IO_ADDR == dma_regs_pkg::PORT_MASTER_CLEAR;
  // Write-only ports answer nothing; the bus keeps its float value
  wire [7:0] read_byte = word_port ? word_byte :
      IO_ADDR == dma_regs_pkg::PORT_CMD_STATUS ? status_byte : temp;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IO_DATA_OUT <= 8'h00;
      IO_DATA_OE <= 1'b0;
      COMMAND <= '0;
      CHANNEL_MASK <= dma_regs_pkg::MASK_RESET;
      SOFTWARE_REQUEST <= 4'h0;
      BYTE_POINTER <= 1'b0;
    end else begin
      if (read_pulse) begin
        IO_DATA_OUT <= read_byte;
      end
      IO_DATA_OE <= ~io_read_strobe_n & readable;
      COMMAND.mem_to_mem <= m2m;
      COMMAND.addr_hold <= m2m & command[dma_regs_pkg::CMD_ADDR_HOLD];
      COMMAND.disable_all <= command[dma_regs_pkg::CMD_DISABLE];
      COMMAND.compressed <= comp;
      COMMAND.rotating <= command[dma_regs_pkg::CMD_ROTATING];
      COMMAND.ext_write <= ~comp & command[dma_regs_pkg::CMD_EXT_WRITE];
      COMMAND.req_active_low <= command[dma_regs_pkg::CMD_REQ_LOW];
      COMMAND.grant_active_high <= command[dma_regs_pkg::CMD_GRANT_HIGH];
      CHANNEL_MASK <= mask;
      SOFTWARE_REQUEST <= request;
      BYTE_POINTER <= pointer;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_pointer_clear: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    pointer_clear_write |=> !pointer)
    else $error("byte pointer not cleared");
  chk_pointer_toggle: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    word_access && !master_clear |=> pointer != $past(pointer))
    else $error("byte pointer did not toggle");
  chk_clear_masks: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    clear_masks_write |=> ##1 CHANNEL_MASK == 4'h0)
    else $error("masks not cleared");
  chk_all_masks: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    all_masks_write |=> mask == $past(IO_DATA_IN[3:0]))
    else $error("all-mask load wrong");
  chk_single_mask: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    single_mask_write |=> mask[$past(sel_chan)] == $past(sel_set))
    else $error("single mask update wrong");
  chk_soft_request: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    request_write |=> ##1
      SOFTWARE_REQUEST[$past(sel_chan, 2)] == $past(sel_set, 2))
    else $error("software request wrong");
  chk_addr_low: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    write_pulse && word_port && !count_port && !pointer |=>
      cur_addr[$past(word_chan)][7:0] == $past(IO_DATA_IN))
    else $error("address low byte not loaded");
  chk_addr_high: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    write_pulse && word_port && !count_port && pointer |=>
      cur_addr[$past(word_chan)][15:8] == $past(IO_DATA_IN))
    else $error("address high byte not loaded");
  chk_count_high: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    write_pulse && word_port && count_port && pointer |=>
      cur_cnt[$past(word_chan)][15:8] == $past(IO_DATA_IN))
    else $error("count high byte not loaded");
  chk_hold_gated: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !COMMAND.mem_to_mem |-> !COMMAND.addr_hold)
    else $error("address hold without mem-to-mem");
  chk_command_load: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    command_write |=> command == $past(IO_DATA_IN))
    else $error("command not loaded");
  chk_tc_sticky: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    TERMINAL_COUNT != 4'h0 && !master_clear |=> (tc_flag & $past(TERMINAL_COUNT)) != 4'h0)
    else $error("terminal count lost");
  chk_status_clear: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    status_read && TERMINAL_COUNT == 4'h0 |=> tc_flag == 4'h0)
    else $error("terminal flags kept after status read");
  chk_mode_load: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    mode_write |=> CHANNEL_MODE[$past(sel_chan)].op == $past(IO_DATA_IN[7:6]))
    else $error("mode not loaded");
  chk_mode_cascade: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    mode_write && cascade_in |=> CHANNEL_MODE[$past(sel_chan)].xfer == dma_regs_pkg::VERIFY_XFER)
    else $error("cascade channel kept a transfer type");
  chk_read_refused: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    read_pulse && !readable |=> !IO_DATA_OE)
    else $error("write-only port drove the bus");
  chk_master_clear: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    master_clear |=> command == dma_regs_pkg::COMMAND_RESET &&
      mask == dma_regs_pkg::MASK_RESET && !pointer)
    else $error("master clear incomplete");
  chk_temp_load: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    TEMP_LOAD && !master_clear |=> temp == $past(TEMP_DATA))
    else $error("temporary register not loaded");

  cov_word_pair: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
    word_access && !pointer ##[1:20] word_access && pointer);
  cov_master_clear: cover property (@(posedge REF_CLK) disable iff (!RESET_N) master_clear);
  cov_status_read: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
    status_read && tc_flag != 4'h0);
  cov_cascade_mode: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
    mode_write && cascade_in);
  cov_refused_read: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
    read_pulse && !readable);

endmodule

// ==== bench/dma_host_model.sv ====
// Host-side model: byte-wide I/O master for the transfer controller ports
module dma_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic      [3:0] io_addr,
  output logic      [7:0] io_data,
  output logic            wr_n,
  output logic            rd_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    io_addr = 4'h0;
    io_data = 8'h00;
    wr_n = 1'b1;
    rd_n = 1'b1;
  end

  // ------------------------------------------------------------
  // Accesses: strobe low three edges, then high at least three
  // ------------------------------------------------------------
  task automatic write_port(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_data = d;
    wr_n = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    wr_n = 1'b1;
    // Released bus must not keep showing the written byte
    io_data = ~d;
    repeat (2) @(negedge clk);
  endtask

  task automatic read_port(input logic [3:0] a, output logic [7:0] d, output logic oe);
    @(negedge clk);
    io_addr = a;
    rd_n = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    d = data_out;
    oe = data_oe;
    rd_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
endmodule

// ==== bench/four_channel_dma_register_interface_tb_top.sv ====
// Self-checking bench for the transfer controller register file
module four_channel_dma_register_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CMDS [3] = '{8'hfe, 8'h39, 8'h00};
  localparam logic [7:0] MODE_W [4] = '{8'h14, 8'h69, 8'hb6, 8'hcf};
  localparam logic [5:0] MODE_E [4] = '{6'h05, 6'h1a, 6'h2d, 6'h30};
  logic        ref_clk;
  logic        reset_n;
  logic [3:0]  io_addr;
  logic [7:0]  io_data;
  logic        wr_n;
  logic        rd_n;
  logic [3:0]  tc;
  logic [3:0]  req_in;
  logic [7:0]  temp_data;
  logic        temp_load;
  logic [7:0]  data_out;
  logic        data_oe;
  logic [3:0]  mask;
  logic [3:0]  sw_req;
  logic [63:0] base_addr;
  logic [63:0] base_count;
  logic        pointer;
  logic [7:0]  rd_data;
  logic        rd_oe;
  int          n_mismatch;
  int          check_count;
  dma_regs_pkg::effective_cmd_type command;
  dma_regs_pkg::mode_type [3:0]    mode;

  dma_register_file i_dma_register_file (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .IO_ADDR(io_addr), .IO_DATA_IN(io_data),
    .io_write_strobe_n(wr_n), .io_read_strobe_n(rd_n), .TERMINAL_COUNT(tc),
    .channel_request_in(req_in), .TEMP_DATA(temp_data), .TEMP_LOAD(temp_load),
    .IO_DATA_OUT(data_out), .IO_DATA_OE(data_oe), .COMMAND(command),
    .CHANNEL_MASK(mask), .SOFTWARE_REQUEST(sw_req), .CHANNEL_MODE(mode),
    .BASE_ADDRESS(base_addr), .BASE_COUNT(base_count), .BYTE_POINTER(pointer)
  );

  dma_host_model i_dma_host_model (
    .clk(ref_clk), .data_out(data_out), .data_oe(data_oe), .io_addr(io_addr),
    .io_data(io_data), .wr_n(wr_n), .rd_n(rd_n)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Struct order runs from command bit 0 down to bit 7
  function automatic logic [7:0] cmd_expect(input logic [7:0] w);
    logic [7:0] e;
    e = w;
    e[1] = w[1] & w[0];
    e[3] = w[3] & ~w[0];
    e[5] = w[5] & ~e[3];
    return {e[0], e[1], e[2], e[3], e[4], e[5], e[6], e[7]};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_dma_host_model.write_port(a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    i_dma_host_model.read_port(a, rd_data, rd_oe);
    check(64'({rd_oe, rd_data}), 64'({1'b1, e}));
  endtask

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] w;
    n_mismatch = 0;
    check_count = 0;
    reset_n = 1'b0;
    tc = 4'h0;
    req_in = 4'h0;
    temp_data = 8'h00;
    temp_load = 1'b0;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(64'({command, mask, sw_req, pointer}), 64'({8'h00, 4'hf, 4'h0, 1'b0}));
    check(base_addr | base_count, 64'h0);
    for (int ch = 0; ch < 4; ch++) begin
      for (int k = 0; k < 2; k++) begin
        w = 16'ha5c3 ^ (16'h1111 * 16'(ch)) ^ 16'(k);
        wr(4'(2 * ch + k), w[7:0]);
        check(64'(pointer), 64'h1);
        wr(4'(2 * ch + k), w[15:8]);
        check(64'(pointer), 64'h0);
        check(64'(k ? base_count[16*ch +: 16] : base_addr[16*ch +: 16]), 64'(w));
        rd(4'(2 * ch + k), w[7:0]);
        rd(4'(2 * ch + k), w[15:8]);
      end
    end
    wr(4'h0, 8'h11);
    wr(4'hc, 8'h00);
    check(64'(pointer), 64'h0);
    rd(4'h0, 8'h11);
    wr(4'hc, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(4'h8, CMDS[i]);
      check(64'(command), 64'(cmd_expect(CMDS[i])));
    end
    @(negedge ref_clk);
    req_in = 4'b0101;
    tc = 4'b0010;
    @(negedge ref_clk);
    tc = 4'b0000;
    rd(4'h8, 8'h52);
    rd(4'h8, 8'h50);
    wr(4'h8, 8'h40);
    rd(4'h8, 8'ha0);
    wr(4'h8, 8'h00);
    wr(4'h9, 8'hff);
    check(64'(sw_req), 64'h8);
    rd(4'h8, 8'hd0);
    wr(4'h9, 8'hfb);
    check(64'(sw_req), 64'h0);
    i_dma_host_model.read_port(4'h9, rd_data, rd_oe);
    check(64'(rd_oe), 64'h0);
    wr(4'he, 8'h00);
    check(64'(mask), 64'h0);
    wr(4'ha, 8'hfd);
    check(64'(mask), 64'h2);
    wr(4'hf, 8'hf9);
    check(64'(mask), 64'h9);
    wr(4'ha, 8'hf8);
    check(64'(mask), 64'h8);
    for (int i = 0; i < 4; i++) begin
      wr(4'hb, MODE_W[i]);
      check(64'(mode[i]), 64'(MODE_E[i]));
    end
    @(negedge ref_clk);
    temp_data = 8'h5a;
    temp_load = 1'b1;
    @(negedge ref_clk);
    temp_load = 1'b0;
    rd(4'hd, 8'h5a);
    wr(4'h9, 8'h04);
    wr(4'h8, 8'h10);
    wr(4'h1, 8'h77);
    wr(4'hd, 8'h00);
    check(64'({command, mask, sw_req, pointer}), 64'({8'h00, 4'hf, 4'h0, 1'b0}));
    rd(4'hd, 8'h00);
    conclude();
  end
endmodule
